/* logic/tcr_reg_bank.sv */
// Register bank of the timing card: resets, status flags, multi-byte fields
`timescale 1ns/1ps
module tcr_reg_bank
   import tcr_pkg::*;
(
   // Clock and pin reset
   input  wire logic     mclk,
   input  wire logic     reset_n,
   // Register access from the serial port block
   input  wire tcr_req_t req,
   output tcr_rsp_t      rsp,
   // Configuration straps (pins)
   input  wire logic [3:0]  cfgPins,
   // Device status sources
   input  wire logic [18:0] measFreq,
   input  wire logic [15:0] phaseIn,
   input  wire logic [3:0]  evtSrc,
   input  wire logic [7:0]  lockSrc,
   // Configuration and control outputs
   output tcr_cfg_t      cfgOut,
   output logic          softResetOut,
   output logic          irqOutput
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  cfgSync1;
      logic [3:0]  cfgSync2;
      logic [1:0]  strapWait;
      logic [3:0]  strapPinVal;
      tcr_cfg_t    cfg;
      logic        softRst;
      logic [4:0]  intEn;
      logic [4:0]  stat4;
      logic [7:0]  lockFlag;
      logic [3:0]  evtPrev;
      logic [7:0]  lockPrev;
      tcr_mb_t     mbState;
      logic [2:0]  mbField;
      logic [2:0]  mbSeen;
      logic [23:0] mbBuf;
      tcr_rsp_t    rsp;
      logic        irq;
   } tcr_state_t;

   tcr_state_t s_reg;
   tcr_state_t s_next;

   tcr_hit_t    look;
   logic        useHit;
   logic        cont;
   logic        abortEv;
   logic [23:0] live;
   logic [23:0] buf24;
   logic [2:0]  posBit;
   logic [2:0]  seen;
   logic [2:0]  fullMask;
   logic [3:0]  evtSet;
   logic [7:0]  lockSet;
   logic [4:0]  clr4;
   logic [7:0]  lockClr;
   logic [7:0]  rd;
   logic        wrReq;
   logic        rdReq;

   // ---------------------------------------------------------------
   // Address decode of multi-byte fields
   // ---------------------------------------------------------------
   // field byte map
   function automatic tcr_hit_t fieldOf(input logic [8:0] a);
      tcr_hit_t h;
      h = '{hit: 1'b1, ro: 1'b0, fld: FLD_OSC, pos: 2'h0};
      case (a)
         ADDR_MEASURED_FREQUENCY_FIELD_LOW: begin h.ro = 1'b1; h.fld = FLD_MEASURED_FREQUENCY_FIELD; end
         ADDR_MEASURED_FREQUENCY_FIELD_MID: begin h.ro = 1'b1; h.fld = FLD_MEASURED_FREQUENCY_FIELD; h.pos = 2'h1; end
         ADDR_MEASURED_FREQUENCY_FIELD_TOP: begin h.ro = 1'b1; h.fld = FLD_MEASURED_FREQUENCY_FIELD; h.pos = 2'h2; end
         ADDR_OSC_LOW:  h.fld = FLD_OSC;
         ADDR_OSC_HIGH: begin h.fld = FLD_OSC; h.pos = 2'h1; end
         ADDR_HOLD_LOW: h.fld = FLD_HOLD;
         ADDR_HOLD_MID: begin h.fld = FLD_HOLD; h.pos = 2'h1; end
         ADDR_HOLD_TOP: begin h.fld = FLD_HOLD; h.pos = 2'h2; end
         ADDR_LIM_LOW:  h.fld = FLD_LIM;
         ADDR_LIM_HIGH: begin h.fld = FLD_LIM; h.pos = 2'h1; end
         ADDR_DIV_LOW:  h.fld = FLD_DIV;
         ADDR_DIV_HIGH: begin h.fld = FLD_DIV; h.pos = 2'h1; end
         ADDR_OFF_LOW:  h.fld = FLD_OFF;
         ADDR_OFF_HIGH: begin h.fld = FLD_OFF; h.pos = 2'h1; end
         ADDR_PH_LOW:   begin h.ro = 1'b1; h.fld = FLD_PHASE; end
         ADDR_PH_HIGH:  begin h.ro = 1'b1; h.fld = FLD_PHASE; h.pos = 2'h1; end
         default:       h.hit = 1'b0;
      endcase
      return h;
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      s_next   = s_reg;
      rd       = 8'h00;
      wrReq    = req.valid & req.write;
      rdReq    = req.valid & ~req.write;
      look     = fieldOf(req.addr);
      // writes to read-only fields change no field but still abort a pending sequence
      useHit   = req.valid & look.hit & ~(req.write & look.ro);
      posBit   = 3'(3'h1 << look.pos);
      fullMask = (look.fld == FLD_MEASURED_FREQUENCY_FIELD || look.fld == FLD_HOLD) ? MASK_THREE : MASK_TWO;

      // Strap synchroniser and capture after pin reset release
      s_next.cfgSync1 = cfgPins;
      s_next.cfgSync2 = s_reg.cfgSync1;
      if (s_reg.strapWait != 2'h0) begin
         s_next.strapWait = s_reg.strapWait - 2'h1;
      end
      // straps latched from the synchroniser on the third clock edge after reset pin goes high
      if (s_reg.strapWait == 2'h1) begin
         s_next.strapPinVal = s_reg.cfgSync2;
         s_next.cfg.strap   = s_reg.cfgSync2;
      end

      // Edge detection of status sources
      // per-bit edge selection
      evtSet           = (evtSrc & ~s_reg.evtPrev & EVT_RISE) | (~evtSrc & s_reg.evtPrev & EVT_FALL);
      lockSet          = lockSrc & ~s_reg.lockPrev;
      s_next.evtPrev   = evtSrc;
      s_next.lockPrev  = lockSrc;

      // Live value of the addressed field
      case (look.fld)
         FLD_MEASURED_FREQUENCY_FIELD:  live = {5'h00, measFreq};
         FLD_OSC:   live = {8'h00, s_reg.cfg.osc};
         FLD_HOLD:  live = {5'h00, s_reg.cfg.hold};
         FLD_LIM:   live = {14'h0000, s_reg.cfg.lim};
         FLD_DIV:   live = {8'h00, s_reg.cfg.div};
         FLD_OFF:   live = {8'h00, s_reg.cfg.off};
         FLD_PHASE: live = {8'h00, phaseIn};
         default:   live = 24'h000000;
      endcase

      // one sequence tracked; anything else interrupts
      cont    = useHit & (s_reg.mbState != MB_IDLE) & (look.fld == s_reg.mbField)
                & ((s_reg.mbState == MB_WRITE) == req.write) & ~|(s_reg.mbSeen & posBit);
      abortEv = req.valid & (s_reg.mbState != MB_IDLE) & ~cont;
      if (abortEv) begin
         s_next.mbState = MB_IDLE;
         s_next.mbSeen  = 3'h0;
      end

      // continuing reads use the frozen snapshot
      buf24 = cont ? s_reg.mbBuf : live;
      seen  = cont ? (s_reg.mbSeen | posBit) : posBit;
      if (req.write) begin
         case (look.pos)
            2'h0:    buf24[7:0]   = req.data;
            2'h1:    buf24[15:8]  = req.data;
            default: buf24[23:16] = req.data;
         endcase
      end

      // Multi-byte sequence step
      if (useHit) begin
         case (look.pos)
            2'h0:    rd = buf24[7:0];
            2'h1:    rd = buf24[15:8];
            default: rd = buf24[23:16];
         endcase
         if (look.fld == FLD_HOLD && look.pos == 2'h2) begin
            rd = {s_reg.cfg.holdCtrl, buf24[18:16]};
         end
         if (seen == fullMask) begin
            s_next.mbState = MB_IDLE;
            s_next.mbSeen  = 3'h0;
            // commit only when every byte arrived
            if (req.write) begin
               case (look.fld)
                  FLD_OSC:  s_next.cfg.osc  = buf24[15:0];
                  FLD_HOLD: s_next.cfg.hold = buf24[18:0];
                  FLD_LIM:  s_next.cfg.lim  = buf24[9:0];
                  FLD_DIV:  s_next.cfg.div  = buf24[15:0];
                  FLD_OFF:  s_next.cfg.off  = buf24[15:0];
                  default:  s_next.cfg.osc  = s_reg.cfg.osc;
               endcase
            end
         end else begin
            s_next.mbState = req.write ? MB_WRITE : MB_READ;
            s_next.mbField = look.fld;
            s_next.mbSeen  = seen;
            s_next.mbBuf   = buf24;
         end
      end

      // upper holdover control bits written at once
      if (wrReq && req.addr == ADDR_HOLD_TOP) begin
         s_next.cfg.holdCtrl = req.data[7:HCTRL_LSB];
      end

      // Single registers
      clr4    = 5'h00;
      lockClr = 8'h00;
      case (req.addr)
         ADDR_CTRL_ONE: begin
            rd = {s_reg.softRst, 3'h0, s_reg.cfg.strap};
            if (wrReq) begin
               s_next.softRst   = req.data[SRST_BIT];
               s_next.cfg.strap = req.data[3:0];
            end
         end
         ADDR_STAT_FOUR: begin
            rd = {3'h0, s_reg.stat4};
            if (wrReq) begin
               clr4 = req.data[4:0];
            end
         end
         ADDR_INT_EN: begin
            rd = {3'h0, s_reg.intEn};
            if (wrReq) begin
               s_next.intEn = req.data[4:0];
            end
         end
         // source level at the moment of read
         ADDR_RT_STAT: rd = {4'h0, evtSrc};
         ADDR_LOCK_FLAG: begin
            rd = s_reg.lockFlag;
            if (wrReq) begin
               lockClr = ~req.data;
            end
         end
         default: rd = rd;
      endcase

      // write-1 clears status, write-0 clears lock flags, a new event wins
      s_next.stat4    = (s_reg.stat4 & ~clr4) | {evtSet, abortEv};
      s_next.lockFlag = (s_reg.lockFlag & ~lockClr) | lockSet;

      // soft reset of everything but the host side
      if (s_reg.softRst) begin
         s_next.cfg      = '{osc: OSC_DEF, hold: HOLD_DEF, holdCtrl: HCTRL_DEF, lim: LIM_DEF,
                             div: DIV_DEF, off: OFF_DEF, strap: s_reg.strapPinVal};
         s_next.intEn    = IEN_DEF;
         s_next.stat4    = 5'h00;
         s_next.lockFlag = 8'h00;
      end

      // enabled latched bits drive the request; lock flags excluded
      s_next.irq      = |(s_next.stat4 & s_next.intEn);
      s_next.rsp.ack  = req.valid;
      s_next.rsp.data = rdReq ? rd : 8'h00;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // pin reset acts without the clock
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg           <= '0;
         s_reg.strapWait <= STRAP_WAIT;
         s_reg.mbState   <= MB_IDLE;
         s_reg.cfg       <= '{osc: OSC_DEF, hold: HOLD_DEF, holdCtrl: HCTRL_DEF, lim: LIM_DEF,
                              div: DIV_DEF, off: OFF_DEF, strap: STRAP_DEF};
         s_reg.intEn     <= IEN_DEF;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign rsp          = s_reg.rsp;
   assign cfgOut       = s_reg.cfg;
   assign softResetOut = s_reg.softRst;
   assign irqOutput    = s_reg.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   ack_after_req_a: assert property (req.valid |=> rsp.ack)
      else $error("request not answered next cycle");

   abort_flag_set_a: assert property (abortEv && !s_reg.softRst |=> s_reg.stat4[ABORT_BIT])
      else $error("abort flag not set on interrupted sequence");

   ro_write_blocked_a: assert property (wrReq && look.hit && look.ro && !s_reg.softRst
      && s_reg.strapWait == 2'h0 |=> $stable(s_reg.cfg))
      else $error("write to read-only field changed configuration");

   irq_from_flag_a: assert property (s_reg.stat4[ABORT_BIT] && s_reg.intEn[ABORT_BIT] |-> irqOutput)
      else $error("enabled flag did not raise interrupt");

   lock_no_irq_a: assert property (((s_reg.stat4 & s_reg.intEn) == 5'h00) |-> !irqOutput)
      else $error("interrupt without enabled latched flag");

   rise_sets_flag_a: assert property (evtSrc[0] && !s_reg.evtPrev[0] && !s_reg.softRst
      |=> s_reg.stat4[1])
      else $error("rising edge did not set latched bit");

   soft_reset_strap_a: assert property (s_reg.softRst && s_reg.strapWait == 2'h0
      |=> s_reg.cfg.strap == $past(s_reg.strapPinVal) && s_reg.cfg.div == DIV_DEF)
      else $error("soft reset did not restore defaults");

   hold_top_now_a: assert property (wrReq && req.addr == ADDR_HOLD_TOP && !s_reg.softRst
      |=> s_reg.cfg.holdCtrl == $past(req.data[7:HCTRL_LSB]))
      else $error("holdover control bits not updated at once");

   div_commit_cause_a: assert property (!$stable(s_reg.cfg.div) |-> $past(s_reg.softRst)
      || $past(wrReq && (req.addr == ADDR_DIV_LOW || req.addr == ADDR_DIV_HIGH)))
      else $error("divider changed without completed write");

   // Host leaves one idle cycle between requests; sequences allow for it
   phase_frozen_a: assert property (rdReq && req.addr == ADDR_PH_LOW && s_reg.mbState == MB_IDLE
      ##1 !req.valid ##1 rdReq && req.addr == ADDR_PH_HIGH |=> rsp.data == $past(phaseIn[15:8], 3))
      else $error("phase high byte not frozen");

   soft_clears_flags_a: assert property (s_reg.softRst
      |=> s_reg.intEn == 5'h00 && s_reg.stat4 == 5'h00 && s_reg.lockFlag == 8'h00)
      else $error("soft reset left flags or enables set");

   rt_status_live_a: assert property (rdReq && req.addr == ADDR_RT_STAT
      |=> rsp.data == {4'h0, $past(evtSrc)})
      else $error("real-time status not live");

   lock_write_zero_a: assert property (wrReq && req.addr == ADDR_LOCK_FLAG && !s_reg.softRst
      |=> s_reg.lockFlag == (($past(s_reg.lockFlag) & $past(req.data)) | $past(lockSet)))
      else $error("lock flags not cleared by zero");

   stat_write_one_a: assert property (wrReq && req.addr == ADDR_STAT_FOUR && !s_reg.softRst
      |=> (s_reg.stat4 & $past(req.data[4:0]) & ~$past({evtSet, abortEv})) == 5'h00)
      else $error("latched bit not cleared by one");

   wr_abort_keeps_a: assert property (abortEv && s_reg.mbState == MB_WRITE && !s_reg.softRst
      |=> $stable({s_reg.cfg.osc, s_reg.cfg.hold, s_reg.cfg.lim, s_reg.cfg.div, s_reg.cfg.off}))
      else $error("aborted write changed a field");

   // Main scenarios, with the idle cycle between host requests
   wr_done_c: cover property (wrReq && req.addr == ADDR_DIV_LOW ##2 wrReq && req.addr == ADDR_DIV_HIGH);
   rd_done_c: cover property (rdReq && req.addr == ADDR_MEASURED_FREQUENCY_FIELD_LOW ##2 rdReq && req.addr == ADDR_MEASURED_FREQUENCY_FIELD_MID
      ##2 rdReq && req.addr == ADDR_MEASURED_FREQUENCY_FIELD_TOP);
   abort_c:   cover property (abortEv);
   soft_c:    cover property (s_reg.softRst ##1 !s_reg.softRst);

endmodule // tcr_reg_bank

/* pkg/tcr_pkg.sv */
// Package for the timing-card register bank: offsets, fields, defaults, types
package tcr_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [8:0] ADDR_MEASURED_FREQUENCY_FIELD_TOP  = 9'h007;
   localparam logic [8:0] ADDR_MEASURED_FREQUENCY_FIELD_LOW  = 9'h00C;
   localparam logic [8:0] ADDR_MEASURED_FREQUENCY_FIELD_MID  = 9'h00D;
   localparam logic [8:0] ADDR_OSC_LOW   = 9'h03C;
   localparam logic [8:0] ADDR_OSC_HIGH  = 9'h03D;
   localparam logic [8:0] ADDR_HOLD_LOW  = 9'h03E;
   localparam logic [8:0] ADDR_HOLD_MID  = 9'h03F;
   localparam logic [8:0] ADDR_HOLD_TOP  = 9'h040;
   localparam logic [8:0] ADDR_LIM_LOW   = 9'h041;
   localparam logic [8:0] ADDR_LIM_HIGH  = 9'h042;
   localparam logic [8:0] ADDR_DIV_LOW   = 9'h046;
   localparam logic [8:0] ADDR_DIV_HIGH  = 9'h047;
   localparam logic [8:0] ADDR_OFF_LOW   = 9'h070;
   localparam logic [8:0] ADDR_OFF_HIGH  = 9'h071;
   localparam logic [8:0] ADDR_PH_LOW    = 9'h077;
   localparam logic [8:0] ADDR_PH_HIGH   = 9'h078;
   localparam logic [8:0] ADDR_CTRL_ONE  = 9'h100;
   localparam logic [8:0] ADDR_STAT_FOUR = 9'h101;
   localparam logic [8:0] ADDR_INT_EN    = 9'h102;
   localparam logic [8:0] ADDR_RT_STAT   = 9'h103;
   localparam logic [8:0] ADDR_LOCK_FLAG = 9'h104;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int         SRST_BIT   = 7;
   localparam int         ABORT_BIT  = 0;
   localparam int         HCTRL_LSB  = 3;
   localparam logic [3:0] EVT_RISE   = 4'h5;
   localparam logic [3:0] EVT_FALL   = 4'h6;
   localparam logic [2:0] FLD_MEASURED_FREQUENCY_FIELD   = 3'h0;
   localparam logic [2:0] FLD_OSC    = 3'h1;
   localparam logic [2:0] FLD_HOLD   = 3'h2;
   localparam logic [2:0] FLD_LIM    = 3'h3;
   localparam logic [2:0] FLD_DIV    = 3'h4;
   localparam logic [2:0] FLD_OFF    = 3'h5;
   localparam logic [2:0] FLD_PHASE  = 3'h6;
   localparam logic [2:0] MASK_THREE = 3'h7;
   localparam logic [2:0] MASK_TWO   = 3'h3;

   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [15:0] OSC_DEF    = 16'h0000;
   localparam logic [18:0] HOLD_DEF   = 19'h00000;
   localparam logic [4:0]  HCTRL_DEF  = 5'h00;
   localparam logic [9:0]  LIM_DEF    = 10'h000;
   localparam logic [15:0] DIV_DEF    = 16'h0000;
   localparam logic [15:0] OFF_DEF    = 16'h0000;
   localparam logic [3:0]  STRAP_DEF  = 4'h0;
   localparam logic [4:0]  IEN_DEF    = 5'h00;
   localparam logic [1:0]  STRAP_WAIT = 2'h3;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MB_IDLE  = 3'b001,
      MB_WRITE = 3'b010,
      MB_READ  = 3'b100
   } tcr_mb_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [8:0] addr;
      logic [7:0] data;
   } tcr_req_t;

   typedef struct packed {
      logic       ack;
      logic [7:0] data;
   } tcr_rsp_t;

   typedef struct packed {
      logic [15:0] osc;
      logic [18:0] hold;
      logic [4:0]  holdCtrl;
      logic [9:0]  lim;
      logic [15:0] div;
      logic [15:0] off;
      logic [3:0]  strap;
   } tcr_cfg_t;

   typedef struct packed {
      logic       hit;
      logic       ro;
      logic [2:0] fld;
      logic [1:0] pos;
   } tcr_hit_t;

endpackage

/* sim/tcr_host_model.sv */
// Host processor model that drives the register port of the bank
`timescale 1ns/1ps
module tcr_host_model
   import tcr_pkg::*;
#(
   parameter int WAIT_CYC = 10000
)
(
   // Clock
   input  wire logic     mclk,
   // Register port
   output tcr_req_t      req,
   input  wire tcr_rsp_t rsp
);

   // ---------------------------------------------------------------
   // Bus access
   // ---------------------------------------------------------------

   // Idle request before the first access
   initial begin
      req = '{valid: 1'b0, write: 1'b0, addr: 9'h1AA, data: 8'h55};
   end

   task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d,
                         output logic [7:0] rdData, output logic ackSeen);
      @(posedge mclk);
      #1;
      req = '{valid: 1'b1, write: w, addr: a, data: d};
      @(posedge mclk);
      #1;
      ackSeen = rsp.ack;
      rdData  = rsp.data;
      // Released lines show the inverse of the last value
      req     = '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
   endtask

   // ---------------------------------------------------------------
   // Start-up sequence
   // ---------------------------------------------------------------
   task automatic initDevice();
      logic [7:0] rdData;
      logic       ackSeen;
      repeat (WAIT_CYC) @(posedge mclk);
      access(1'b1, 9'h180, 8'h00, rdData, ackSeen);
   endtask

endmodule // tcr_host_model

/* sim/tcr_reg_bank_bench.sv */
// Self-checking testbench of the timing-card register bank
`timescale 1ns/1ps
module tcr_reg_bank_bench;
   import tcr_pkg::*;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam int LIMIT = 40000;
   logic        mclk;
   logic        reset_n;
   tcr_req_t    req;
   tcr_rsp_t    rsp;
   logic [3:0]  cfgPins;
   logic [18:0] measFreq;
   logic [15:0] phaseIn;
   logic [3:0]  evtSrc;
   logic [7:0]  lockSrc;
   tcr_cfg_t    cfgOut;
   logic        softResetOut;
   logic        irqOutput;
   logic [7:0]  rdData;
   logic        ackSeen;
   int          failures;
   int          comparisons;
   int          cycles;

   // Clock of 10 ns
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   tcr_reg_bank dut (.mclk(mclk), .reset_n(reset_n), .req(req), .rsp(rsp), .cfgPins(cfgPins),
                     .measFreq(measFreq), .phaseIn(phaseIn), .evtSrc(evtSrc), .lockSrc(lockSrc),
                     .cfgOut(cfgOut), .softResetOut(softResetOut), .irqOutput(irqOutput));

   tcr_host_model host (.mclk(mclk), .req(req), .rsp(rsp));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      host.access(1'b1, a, d, rdData, ackSeen);
   endtask

   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      host.access(1'b0, a, 8'h00, rdData, ackSeen);
      check(ackSeen, 1'b1);
      check(rdData, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   function automatic tcr_cfg_t defCfg(input logic [3:0] s);
      return {OSC_DEF, HOLD_DEF, HCTRL_DEF, LIM_DEF, DIV_DEF, OFF_DEF, s};
   endfunction

   // Cut a hang short
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      // pulse the reset pin after power-up
      reset_n = 1'b0;
      cfgPins = 4'hA;
      measFreq = 19'h00000;
      phaseIn = 16'h0000;
      evtSrc = 4'h0;
      lockSrc = 8'h00;
      failures = 0;
      comparisons = 0;
      cycles = 0;
      tick(5);
      reset_n = 1'b1;
      tick(4);
      check(cfgOut, defCfg(4'hA));
      host.initDevice();
      // Multi-byte write and read back
      wr(ADDR_DIV_LOW, 8'h34);
      check(cfgOut.div, DIV_DEF);
      wr(ADDR_DIV_HIGH, 8'h12);
      check(cfgOut.div, 16'h1234);
      rd(ADDR_DIV_LOW, 8'h34);
      rd(ADDR_DIV_HIGH, 8'h12);
      // Interrupted write, flag clear by one only
      wr(ADDR_OFF_LOW, 8'h55);
      rd(ADDR_CTRL_ONE, 8'h0A);
      check(cfgOut.off, OFF_DEF);
      rd(ADDR_STAT_FOUR, 8'h01);
      wr(ADDR_STAT_FOUR, 8'h00);
      rd(ADDR_STAT_FOUR, 8'h01);
      wr(ADDR_STAT_FOUR, 8'h01);
      rd(ADDR_STAT_FOUR, 8'h00);
      // Another field interrupts
      wr(ADDR_OSC_LOW, 8'h11);
      wr(ADDR_LIM_LOW, 8'h22);
      wr(ADDR_LIM_HIGH, 8'h03);
      check(cfgOut.lim, 10'h322);
      check(cfgOut.osc, OSC_DEF);
      rd(ADDR_STAT_FOUR, 8'h01);
      wr(ADDR_STAT_FOUR, 8'h01);
      // Read freeze, abort and unfreeze
      phaseIn = 16'h1234;
      rd(ADDR_PH_LOW, 8'h34);
      phaseIn = 16'hABCD;
      rd(ADDR_PH_HIGH, 8'h12);
      rd(ADDR_PH_LOW, 8'hCD);
      rd(ADDR_RT_STAT, 8'h00);
      phaseIn = 16'h5678;
      rd(ADDR_PH_HIGH, 8'h56);
      rd(ADDR_PH_LOW, 8'h78);
      rd(ADDR_STAT_FOUR, 8'h01);
      wr(ADDR_STAT_FOUR, 8'h01);
      // Measured frequency, write ignored
      measFreq = 19'h5A3C1;
      wr(ADDR_MEASURED_FREQUENCY_FIELD_LOW, 8'hFF);
      rd(ADDR_MEASURED_FREQUENCY_FIELD_LOW, 8'hC1);
      rd(ADDR_MEASURED_FREQUENCY_FIELD_MID, 8'hA3);
      rd(ADDR_MEASURED_FREQUENCY_FIELD_TOP, 8'h05);
      // Holdover top byte
      wr(ADDR_HOLD_TOP, 8'hF9);
      check(cfgOut.holdCtrl, 5'h1F);
      check(cfgOut.hold, HOLD_DEF);
      wr(ADDR_HOLD_LOW, 8'h11);
      wr(ADDR_HOLD_MID, 8'h22);
      check(cfgOut.hold, 19'h12211);
      rd(ADDR_HOLD_LOW, 8'h11);
      rd(ADDR_HOLD_MID, 8'h22);
      rd(ADDR_HOLD_TOP, 8'hF9);
      // Event flags, edges and interrupt
      wr(ADDR_INT_EN, 8'h1F);
      evtSrc = 4'h1;
      tick(2);
      check(irqOutput, 1'b1);
      rd(ADDR_RT_STAT, 8'h01);
      evtSrc = 4'h2;
      tick(2);
      rd(ADDR_STAT_FOUR, 8'h02);
      evtSrc = 4'h4;
      tick(2);
      evtSrc = 4'h0;
      tick(2);
      rd(ADDR_STAT_FOUR, 8'h0E);
      wr(ADDR_STAT_FOUR, 8'h0E);
      check(irqOutput, 1'b0);
      wr(ADDR_INT_EN, 8'h00);
      evtSrc = 4'h1;
      tick(2);
      check(irqOutput, 1'b0);
      evtSrc = 4'h0;
      wr(ADDR_STAT_FOUR, 8'h02);
      // Lock flags
      wr(ADDR_INT_EN, 8'h1F);
      lockSrc = 8'h81;
      tick(2);
      rd(ADDR_LOCK_FLAG, 8'h81);
      check(irqOutput, 1'b0);
      wr(ADDR_LOCK_FLAG, 8'h7F);
      rd(ADDR_LOCK_FLAG, 8'h01);
      lockSrc = 8'h00;
      // Abort flag raises the request when enabled
      wr(ADDR_DIV_LOW, 8'h01);
      rd(ADDR_INT_EN, 8'h1F);
      check(irqOutput, 1'b1);
      // Soft reset keeps the latched strap
      cfgPins = 4'h5;
      wr(ADDR_CTRL_ONE, 8'h80);
      check(softResetOut, 1'b1);
      // Soft reset takes hold at the next edge
      tick(1);
      check(cfgOut, defCfg(4'hA));
      rd(ADDR_INT_EN, 8'h00);
      rd(ADDR_LOCK_FLAG, 8'h00);
      rd(ADDR_CTRL_ONE, 8'h8A);
      wr(ADDR_CTRL_ONE, 8'h00);
      check(softResetOut, 1'b0);
      host.initDevice();
      wr(ADDR_CTRL_ONE, 8'h03);
      check(cfgOut.strap, 4'h3);
      wr(ADDR_OSC_LOW, 8'h77);
      wr(ADDR_OSC_HIGH, 8'h66);
      check(cfgOut.osc, 16'h6677);
      // Pin reset acts without a clock edge
      reset_n = 1'b0;
      #2;
      check(cfgOut.osc, OSC_DEF);
      tick(5);
      reset_n = 1'b1;
      tick(4);
      check(cfgOut, defCfg(4'h5));
      host.initDevice();
      rd(ADDR_INT_EN, 8'h00);
      conclude();
   end

endmodule // tcr_reg_bank_bench
